/* File: rtl/tma_map.vh */
`ifndef TMA_MAP_VH
`define TMA_MAP_VH

// Register byte offsets
`define TMA_OFS_MODE 8'h00
`define TMA_OFS_CTRL 8'h04
`define TMA_OFS_DATA 8'h08
`define TMA_OFS_TRIG 8'h0c
`define TMA_OFS_STAT 8'h10

// Mode register fields
`define TMA_MODE_LO 0
`define TMA_MODE_HI 1
`define TMA_MODE_PULSE 2
`define TMA_MODE_UDPIN 3
`define TMA_MODE_UDEXT 4
`define TMA_MODE_FREE 5
`define TMA_MODE_CS_LO 6
`define TMA_MODE_CS_HI 7

// Control register fields
`define TMA_CTRL_START 0
`define TMA_CTRL_UP 1
`define TMA_CTRL_OSHOT 2

// Status register fields
`define TMA_STAT_PIN 0
`define TMA_STAT_RUN 1
`define TMA_STAT_DIR 2

// Mode codes
`define TMA_M_TIMER 2'b00
`define TMA_M_EVENT 2'b01
`define TMA_M_ONESHOT 2'b10

// Reset values
`define TMA_RST_MODE 8'h00
`define TMA_RST_TRIG 2'b00
`define TMA_RST_CNT 16'h0000

// Prescaler terminal counts and counter wrap values
`define TMA_DIV8_LAST 3'h7
`define TMA_DIV32_LAST 5'h1f
`define TMA_CNT_ALL1 16'hffff
`define TMA_CNT_ONE 16'h0001

`endif

/* File: rtl/tma_timer.v */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "tma_map.vh"

module tma_timer #(
    parameter CNT_W = 16
) (
    input wire pclk, // System clock
    input wire presetn, // Async reset, active low
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB write
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output wire pready, // APB ready
    output wire pslverr, // APB error on unmapped address
    output reg [31:0] prdata, // APB read data
    input wire subclock_in, // Asynchronous subclock
    input wire companion_timer_b_channel, // Timer B overflow pulse
    input wire neighbour_timer_lower, // Lower timer A overflow pulse
    input wire neighbour_timer_upper, // Upper timer A overflow pulse
    input wire timer_pulse_out_pin_i, // Pin level in
    output reg timer_pulse_out_pin_o, // Pin level out
    output reg timer_pulse_out_pin_oe, // Pin drive enable
    output reg timer_overflow, // Overflow/underflow pulse to neighbours
    output reg irq_req // Interrupt request pulse
);

    // Source select decode for trigger/event inputs
    function src_pick;
        input [1:0] sel;
        input b_ovf;
        input lo_ovf;
        input hi_ovf;
        begin
            case (sel)
                2'b01: src_pick = b_ovf;
                2'b10: src_pick = lo_ovf;
                2'b11: src_pick = hi_ovf;
                // 00 is reserved and yields no event
                default: src_pick = 1'b0;
            endcase
        end
    endfunction

    reg [7:0] mode_r;
    reg [1:0] trig_r;
    reg start_r;
    reg up_r;
    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] cnt_nxt;
    reg [CNT_W-1:0] reload_r;
    reg run_r;
    reg run_nxt;
    reg pin_r;
    reg [4:0] pre_r;
    reg [4:0] sub_div_r;
    reg sub_s1_r;
    reg sub_s2_r;
    reg sub_s3_r;
    reg sub_lvl_r;
    reg ud_s1_r;
    reg ud_s2_r;
    reg ud_s3_r;
    reg ud_lvl_r;
    reg sub_tick_r;
    reg wrap_evt;
    reg src_tick;

    wire [1:0] mode;
    wire [1:0] cs_sel;
    wire acc_wr;
    wire setup_rd;
    wire hit_mode;
    wire hit_ctrl;
    wire hit_data;
    wire hit_trig;
    wire hit_stat;
    wire mapped;
    wire wr_data;
    wire wr_ctrl;
    wire os_sw;
    wire ext_evt;
    wire count_up;
    wire active;
    wire ud_pin_mode;
    wire at_top;
    wire at_zero;
    wire at_one;
    wire os_trig;

    // Register field views
    assign mode = mode_r[`TMA_MODE_HI:`TMA_MODE_LO];
    assign cs_sel = mode_r[`TMA_MODE_CS_HI:`TMA_MODE_CS_LO];
    assign ud_pin_mode = (mode == `TMA_M_EVENT) && mode_r[`TMA_MODE_UDPIN];

    // APB decode
    assign hit_mode = (paddr == `TMA_OFS_MODE);
    assign hit_ctrl = (paddr == `TMA_OFS_CTRL);
    assign hit_data = (paddr == `TMA_OFS_DATA);
    assign hit_trig = (paddr == `TMA_OFS_TRIG);
    assign hit_stat = (paddr == `TMA_OFS_STAT);
    assign mapped = hit_mode | hit_ctrl | hit_data | hit_trig | hit_stat;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    // Writes land in the access phase, reads are captured at setup
    assign acc_wr = psel & penable & pwrite & mapped;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign wr_data = acc_wr & hit_data;
    assign wr_ctrl = acc_wr & hit_ctrl;
    assign os_sw = wr_ctrl & pwdata[`TMA_CTRL_OSHOT];

    // Selected trigger or event overflow
    assign ext_evt = src_pick(trig_r, companion_timer_b_channel,
                              neighbour_timer_lower, neighbour_timer_upper);

    // One-shot trigger: software strobe or selected overflow
    assign os_trig = os_sw | ext_evt;

    // Direction from pin or software bit
    assign count_up = mode_r[`TMA_MODE_UDEXT] ? ud_lvl_r : up_r;

    // Counting in progress decides data write behaviour
    assign active = (mode == `TMA_M_ONESHOT) ? run_r : start_r;

    // Wrap points of the 16-bit counter
    assign at_top = (cnt_r == `TMA_CNT_ALL1);
    assign at_zero = (cnt_r == `TMA_RST_CNT);
    assign at_one = (cnt_r == `TMA_CNT_ONE);

    // Three-stage syncs for subclock and direction pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
            sub_lvl_r <= 1'b0;
            ud_s1_r <= 1'b0;
            ud_s2_r <= 1'b0;
            ud_s3_r <= 1'b0;
            ud_lvl_r <= 1'b0;
        end else begin
            // Subclock level moves once stages two and three agree
            sub_s1_r <= subclock_in;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
            if (sub_s2_r == sub_s3_r) begin
                sub_lvl_r <= sub_s3_r;
            end
            // Direction pin, same three-stage filter
            ud_s1_r <= timer_pulse_out_pin_i;
            ud_s2_r <= ud_s1_r;
            ud_s3_r <= ud_s2_r;
            if (ud_s2_r == ud_s3_r) begin
                ud_lvl_r <= ud_s3_r;
            end
        end
    end

    // Prescaler taps and subclock divider
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 5'h00;
            sub_div_r <= 5'h00;
            sub_tick_r <= 1'b0;
        end else begin
            pre_r <= pre_r + 5'h01;
            sub_tick_r <= 1'b0;
            // One count per filtered subclock rising edge
            if ((sub_s2_r == sub_s3_r) && sub_s3_r && !sub_lvl_r) begin
                sub_div_r <= sub_div_r + 5'h01;
                sub_tick_r <= (sub_div_r == `TMA_DIV32_LAST);
            end
        end
    end

    // Internal count source select
    always @* begin
        case (cs_sel)
            2'b00: src_tick = 1'b1;
            2'b01: src_tick = (pre_r[2:0] == `TMA_DIV8_LAST);
            2'b10: src_tick = (pre_r == `TMA_DIV32_LAST);
            default: src_tick = sub_tick_r;
        endcase
    end

    // Counter next state per mode
    always @* begin
        cnt_nxt = cnt_r;
        run_nxt = run_r;
        wrap_evt = 1'b0;
        case (mode)
            `TMA_M_TIMER: begin
                // Divider mode; a one-shot left running must not resume later
                run_nxt = 1'b0;
                if (start_r && src_tick) begin
                    if (at_zero) begin
                        cnt_nxt = reload_r;
                        wrap_evt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
            end
            `TMA_M_EVENT: begin
                // Overflow counting; no one-shot stays armed
                run_nxt = 1'b0;
                if (start_r && ext_evt) begin
                    if (count_up && at_top) begin
                        wrap_evt = 1'b1;
                        cnt_nxt = mode_r[`TMA_MODE_FREE] ? `TMA_RST_CNT
                                                         : reload_r;
                    end else if (!count_up && at_zero) begin
                        wrap_evt = 1'b1;
                        cnt_nxt = mode_r[`TMA_MODE_FREE] ? `TMA_CNT_ALL1
                                                         : reload_r;
                    end else if (count_up) begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
            end
            `TMA_M_ONESHOT: begin
                // Clearing start wins over a trigger in the same cycle
                if (!start_r) begin
                    run_nxt = 1'b0;
                end else if (os_trig) begin
                    cnt_nxt = reload_r;
                    run_nxt = 1'b1;
                end else if (run_r && src_tick) begin
                    if (at_one || at_zero) begin
                        cnt_nxt = reload_r;
                        run_nxt = 1'b0;
                        wrap_evt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
            end
            default: begin
                run_nxt = 1'b0;
            end
        endcase
    end

    // Software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `TMA_RST_MODE;
            trig_r <= `TMA_RST_TRIG;
            start_r <= 1'b0;
            up_r <= 1'b0;
        end else begin
            if (acc_wr && hit_mode) begin
                mode_r <= pwdata[7:0];
            end
            // Source select, 00 reserved
            if (acc_wr && hit_trig) begin
                trig_r <= pwdata[1:0];
            end
            // One-shot bit is a strobe and is not stored
            if (wr_ctrl) begin
                start_r <= pwdata[`TMA_CTRL_START];
                up_r <= pwdata[`TMA_CTRL_UP];
            end
        end
    end

    // Counter, reload register and run state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= `TMA_RST_CNT;
            reload_r <= `TMA_RST_CNT;
            run_r <= 1'b0;
        end else begin
            run_r <= run_nxt;
            // Reload takes every data write; counter only while idle
            if (wr_data) begin
                reload_r <= pwdata[CNT_W-1:0];
            end
            if (wr_data && !active) begin
                cnt_r <= pwdata[CNT_W-1:0];
            end else begin
                cnt_r <= cnt_nxt;
            end
        end
    end

    // Events to interrupt, neighbours and pulse pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_req <= 1'b0;
            timer_overflow <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            irq_req <= wrap_evt;
            // Overflow pulse lets neighbouring channels chain
            timer_overflow <= wrap_evt;
            // Pin level flips on each wrap while pulse output is on
            if (wrap_evt && mode_r[`TMA_MODE_PULSE]) begin
                pin_r <= ~pin_r;
            end
        end
    end

    // Pin function: port, pulse output or direction input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_pulse_out_pin_o <= 1'b0;
            timer_pulse_out_pin_oe <= 1'b0;
        end else begin
            timer_pulse_out_pin_o <= pin_r;
            // Direction-input mode releases the pin
            timer_pulse_out_pin_oe <= mode_r[`TMA_MODE_PULSE] & ~ud_pin_mode;
        end
    end

    // Read data captured in setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            // Unmapped addresses fall through and read as zero
            prdata <= 32'h00000000;
            if (hit_mode) begin
                prdata[7:0] <= mode_r;
            end
            if (hit_ctrl) begin
                prdata[`TMA_CTRL_START] <= start_r;
                prdata[`TMA_CTRL_UP] <= up_r;
            end
            if (hit_data) begin
                prdata[CNT_W-1:0] <= cnt_r;
            end
            if (hit_trig) begin
                prdata[1:0] <= trig_r;
            end
            if (hit_stat) begin
                prdata[`TMA_STAT_PIN] <= pin_r;
                prdata[`TMA_STAT_RUN] <= run_r;
                prdata[`TMA_STAT_DIR] <= ud_lvl_r;
            end
        end
    end

endmodule // tma_timer

/* File: verif/tma_timer_chk.sv */
`timescale 1ns/10ps
`include "tma_map.vh"
module tma_timer_chk (
    input wire pclk, // Clock
    input wire presetn, // Reset
    input wire psel, // Select
    input wire penable, // Access
    input wire pwrite, // Write
    input wire [7:0] paddr, // Address
    input wire [31:0] pwdata, // Wdata
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire [31:0] prdata, // Rdata
    input wire companion_timer_b_channel, // Event
    input wire neighbour_timer_lower, // Event
    input wire neighbour_timer_upper, // Event
    input wire timer_pulse_out_pin_oe, // Pin enable
    input wire timer_overflow, // Wrap pulse
    input wire irq_req // Request
);
    reg [7:0] mode_r;
    reg start_r;
    reg [1:0] trig_r;
    wire acc = psel && penable;
    wire bad = paddr > 8'h10 || paddr[1:0] != 2'b00;
    wire ev = trig_r == 2'b01 ? companion_timer_b_channel :
        trig_r == 2'b10 ? neighbour_timer_lower :
        trig_r == 2'b11 ? neighbour_timer_upper : 1'b0;
    // Shadow of written settings
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 8'h00;
            start_r <= 1'b0;
            trig_r <= 2'b00;
        end else if (acc && pwrite) begin
            if (paddr == `TMA_OFS_MODE) mode_r <= pwdata[7:0];
            if (paddr == `TMA_OFS_CTRL) start_r <= pwdata[0];
            if (paddr == `TMA_OFS_TRIG) trig_r <= pwdata[1:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_phase: assert property (pslverr |-> acc) else $error("stray error");
    chk_err_map: assert property (acc |-> pslverr == bad) else $error("error map");
    chk_bad_rdata: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
        else $error("unmapped data");
    chk_irq_ovf: assert property (irq_req == timer_overflow)
        else $error("irq apart from wrap");
    chk_stop_quiet: assert property (
        !start_r && !$past(start_r) && !$past(start_r, 2) |-> !irq_req)
        else $error("irq while stopped");
    chk_event_src: assert property (mode_r[1:0] == 2'b01 && $stable(mode_r)
        && $stable(trig_r) && timer_overflow |-> $past(ev) || $past(ev, 2))
        else $error("event wrap without event");
    chk_dir_oe: assert property (mode_r[1:0] == 2'b01 && mode_r[3] && $stable(mode_r)
        |-> !timer_pulse_out_pin_oe) else $error("pin driven as input");
    chk_pulse_oe: assert property (mode_r[1:0] != 2'b11 && $stable(mode_r)
        && !(mode_r[1:0] == 2'b01 && mode_r[3]) |-> timer_pulse_out_pin_oe == mode_r[2])
        else $error("pulse pin enable");
endmodule // tma_timer_chk
bind tma_timer tma_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .companion_timer_b_channel(companion_timer_b_channel),
    .neighbour_timer_lower(neighbour_timer_lower), .neighbour_timer_upper(neighbour_timer_upper),
    .timer_pulse_out_pin_oe(timer_pulse_out_pin_oe), .timer_overflow(timer_overflow),
    .irq_req(irq_req));

/* File: verif/test_tma_timer.sv */
`timescale 1ns/10ps
`include "tma_map.vh"
`define CK(n, e, g) begin check_count++; if ((e) !== (g)) begin err_total++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module test_tma_timer;
    reg pclk, presetn, psel, penable, pwrite, sub, tb_b, tb_lo, tb_hi, pin_i;
    reg [7:0] paddr;
    reg [31:0] pwdata;
    wire pready, pslverr, pin_o, pin_oe, ovf, irq_req;
    wire [31:0] prdata;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    reg [31:0] q;
    reg e;
    int n, m, k;
    tma_timer u_tma_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .subclock_in(sub), .companion_timer_b_channel(tb_b),
        .neighbour_timer_lower(tb_lo), .neighbour_timer_upper(tb_hi),
        .timer_pulse_out_pin_i(pin_i), .timer_pulse_out_pin_o(pin_o),
        .timer_pulse_out_pin_oe(pin_oe), .timer_overflow(ovf), .irq_req(irq_req));
    // Clock, slow subclock and hang guard
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        sub = 0;
        forever begin
            repeat (3) @(posedge pclk);
            sub <= ~sub;
        end
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            stop_test;
        end
    end
    task stop_test;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One APB transfer, then one idle edge
    task bus(input w, input [7:0] a, input [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task wirq(input int lim, output int c);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (irq_req !== 1'b1 && c < lim);
    endtask
    // Pulses on one source until a wrap shows
    task evs(input [1:0] s, output int c);
        c = 0;
        m = 0;
        while (!m && c < 8) begin
            tb_b <= s == 1;
            tb_lo <= s == 2;
            tb_hi <= s == 3;
            @(posedge pclk);
            {tb_b, tb_lo, tb_hi} <= 3'b000;
            c++;
            repeat (3) begin
                @(posedge pclk);
                if (irq_req === 1'b1) m = 1;
            end
        end
    endtask
    task osh(output int c);
        tb_b <= 1;
        @(posedge pclk);
        tb_b <= 0;
        wirq(100, c);
    endtask
    task t_regs;
        for (int a = 0; a <= 12; a += 4) begin
            bus(0, a, 0);
            `CK("reset value", 32'h0, q)
        end
        bus(0, 8'h14, 0);
        `CK("unmapped", 1'b1, e)
    endtask
    task t_timer;
        int dv[4];
        reg a;
        dv[0] = 1;
        dv[1] = 8;
        dv[2] = 32;
        dv[3] = 192;
        for (int i = 0; i < 4; i++) begin
            bus(1, `TMA_OFS_CTRL, 0);
            bus(1, `TMA_OFS_MODE, (i << 6) | 4);
            bus(1, `TMA_OFS_DATA, 1);
            bus(1, `TMA_OFS_CTRL, 1);
            wirq(500, n);
            wirq(500, n);
            `CK("period", 2 * dv[i], n)
        end
        bus(1, `TMA_OFS_MODE, 4);
        wirq(500, n);
        @(posedge pclk);
        a = pin_o;
        wirq(50, n);
        @(posedge pclk);
        `CK("pin", ~a, pin_o)
        bus(1, `TMA_OFS_DATA, 5);
        wirq(50, n);
        wirq(50, n);
        `CK("new reload", 6, n)
        bus(1, `TMA_OFS_CTRL, 0);
        bus(1, `TMA_OFS_DATA, 9);
        bus(0, `TMA_OFS_DATA, 0);
        `CK("stopped load", 32'h9, q)
        wirq(50, n);
        `CK("stopped", 50, n)
    endtask
    task t_event;
        for (int s = 1; s < 4; s++) begin
            bus(1, `TMA_OFS_CTRL, 0);
            bus(1, `TMA_OFS_MODE, 8'h01);
            bus(1, `TMA_OFS_TRIG, s);
            bus(1, `TMA_OFS_DATA, 2);
            bus(1, `TMA_OFS_CTRL, 1);
            evs(s, n);
            evs(s, k);
            `CK("down", 6, n + k)
            bus(1, `TMA_OFS_CTRL, 0);
            bus(1, `TMA_OFS_DATA, 32'hfffd);
            bus(1, `TMA_OFS_CTRL, 3);
            evs(s, n);
            `CK("up", 3, n)
        end
        bus(1, `TMA_OFS_CTRL, 0);
        bus(1, `TMA_OFS_MODE, 8'h25);
        bus(1, `TMA_OFS_DATA, 1);
        bus(1, `TMA_OFS_CTRL, 1);
        bus(0, `TMA_OFS_STAT, 0);
        k = q;
        evs(3, n);
        bus(0, `TMA_OFS_DATA, 0);
        `CK("free run", 32'hffff, q)
        bus(0, `TMA_OFS_STAT, 0);
        `CK("event pin", !k[0], q[0])
        bus(1, `TMA_OFS_CTRL, 0);
        bus(1, `TMA_OFS_MODE, 8'h1d);
        bus(1, `TMA_OFS_DATA, 32'hfffd);
        bus(1, `TMA_OFS_CTRL, 1);
        evs(3, n);
        `CK("pin up", 3, n)
        `CK("pin input", 1'b0, pin_oe)
    endtask
    task t_one;
        bus(1, `TMA_OFS_CTRL, 0);
        bus(1, `TMA_OFS_MODE, 8'h02);
        bus(1, `TMA_OFS_TRIG, 1);
        bus(1, `TMA_OFS_DATA, 4);
        bus(1, `TMA_OFS_CTRL, 1);
        osh(n);
        bus(1, `TMA_OFS_DATA, 8);
        osh(k);
        `CK("one shot", 4, k - n)
        wirq(40, n);
        `CK("halted", 40, n)
        tb_b <= 1;
        @(posedge pclk);
        tb_b <= 0;
        repeat (3) @(posedge pclk);
        osh(n);
        `CK("retrigger", k, n)
        bus(1, `TMA_OFS_CTRL, 5);
        wirq(40, n);
        `CK("soft start", 1'b1, n < 40)
        tb_b <= 1;
        @(posedge pclk);
        tb_b <= 0;
        bus(1, `TMA_OFS_CTRL, 0);
        wirq(40, n);
        `CK("cleared", 40, n)
        bus(0, `TMA_OFS_STAT, 0);
        `CK("run bit", 1'b0, q[1])
    endtask
    // Reset in mid-run returns outputs and registers to idle
    task t_reset;
        bus(1, `TMA_OFS_MODE, 8'h04);
        bus(1, `TMA_OFS_CTRL, 1);
        presetn <= 0;
        @(posedge pclk);
        `CK("reset irq", 1'b0, irq_req)
        `CK("reset pin", 1'b0, pin_oe)
        presetn <= 1;
        @(posedge pclk);
        bus(0, `TMA_OFS_MODE, 0);
        `CK("mode after reset", 32'h0, q)
        bus(0, `TMA_OFS_CTRL, 0);
        `CK("start after reset", 32'h0, q)
        wirq(20, n);
        `CK("quiet after reset", 20, n)
    endtask
    initial begin
        {presetn, psel, penable, pwrite, tb_b, tb_lo, tb_hi} = 0;
        pin_i = 1;
        paddr = 0;
        pwdata = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_regs;
        t_timer;
        t_event;
        t_one;
        t_reset;
        stop_test;
    end
endmodule // test_tma_timer
